// file: core/dth_pkg.sv
// constants, types and decode helpers for the dma trigger hazard model
// assumes a single 100 MHz system clock shared by every user of the package
package dth_pkg;

  // ==========================================================================
  // timing
  // ==========================================================================
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned MCLK_CYC      = 1;
  localparam int unsigned WIN_NS        = 500;
  // least time: the nanosecond part rounds up to whole cycles
  localparam int unsigned WIN_CYC       = MCLK_CYC + (WIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CLR_RST_CYC   = 4;
  localparam int unsigned CNT_W         = 8;

  // ==========================================================================
  // widths and values after reset
  // ==========================================================================
  localparam int unsigned   ADDR_W       = 16;
  localparam int unsigned   DATA_W       = 16;
  localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
  localparam logic [DATA_W-1:0] CORRUPT_MASK = 16'ha5a5;
  localparam logic [CNT_W-1:0]  CNT_RST  = 8'h00;

  // ==========================================================================
  // power modes and power sequencer states
  // ==========================================================================
  typedef enum logic [2:0] {
    active_mode,
    low_power_mode_zero,
    low_power_mode_one,
    low_power_mode_two,
    low_power_mode_three,
    low_power_mode_four
  } dth_pmode_e;

  typedef enum logic [1:0] {
    PS_RUN,
    PS_ENTRY,
    PS_SLEEP,
    PS_CLEAR
  } dth_pstate_e;

  // one memory write issued by the dma
  typedef struct packed {
    logic              valid;
    logic              corrupt;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } dth_wr_s;

  // true for the deeper sleep modes that carry the trigger hazard
  function automatic logic dth_is_deep(input dth_pmode_e m);
    dth_is_deep = (m == low_power_mode_one) || (m == low_power_mode_two) ||
                  (m == low_power_mode_three) || (m == low_power_mode_four);
  endfunction

endpackage

// file: core/dth_dma_xfer.sv
// single channel dma: one word write per accepted trigger
// assumes triggers and data come from logic on the same clock
`timescale 1ns/1ps
module dth_dma_xfer
  import dth_pkg::*;
(
  input  wire logic                 i_clk,
  input  wire logic                 i_rst,
  input  wire logic                 i_ce,
  input  wire logic                 i_clr,
  input  wire logic                 i_en,
  input  wire logic                 i_trig,
  input  wire logic [DATA_W-1:0]    i_data,
  output logic                      o_start,
  output dth_pkg::dth_wr_s          o_wr
);

  logic [ADDR_W-1:0] addr_ff;
  logic [DATA_W-1:0] data_ff;

  // ==========================================================================
  // accept a trigger, at most every other cycle
  // ==========================================================================
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      o_start <= 1'b0;
    else if (i_ce)
      o_start <= !i_clr && i_en && i_trig && !o_start;
  end

  // capture source word on acceptance
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      data_ff <= DATA_RST;
    else if (i_ce && i_en && i_trig && !o_start)
      data_ff <= i_data;
  end

  // destination pointer walks up one word per transfer
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      addr_ff <= ADDR_RST;
    else if (i_ce)
    begin
      if (i_clr)
        addr_ff <= ADDR_RST;
      else if (o_start)
        addr_ff <= addr_ff + 16'h0001;
    end
  end

  // write issued the cycle after the start
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      o_wr <= '0;
    else if (i_ce)
    begin
      o_wr.valid   <= o_start && !i_clr;
      o_wr.corrupt <= 1'b0;
      o_wr.addr    <= addr_ff;
      o_wr.data    <= data_ff;
    end
  end

endmodule

// file: core/dth_dma_trigger_hazard_model.sv
// dma controller behaviour with its interrupt flag, sleep entry and debug hazards
// assumes cpu access strobes, events and triggers are on i_clk; i_dbg_halt is a pin
`timescale 1ns/1ps
module dth_dma_trigger_hazard_model
  import dth_pkg::*;
#(
  parameter int unsigned NFLAG   = 8,
  parameter int unsigned CLR_LEN = CLR_RST_CYC
)
(
  input  wire logic                 i_clk,
  input  wire logic                 i_rst,
  input  wire logic                 i_ce,
  input  wire logic                 i_dma_en,
  input  wire logic                 i_dma_trig,
  input  wire logic [DATA_W-1:0]    i_src_data,
  input  wire logic [NFLAG-1:0]     i_irq_evt,
  input  wire logic                 i_rmw_rd,
  input  wire logic                 i_rmw_wr,
  input  wire logic [NFLAG-1:0]     i_rmw_clr,
  input  wire dth_pkg::dth_pmode_e  i_lpm_mode,
  input  wire logic                 i_lpm_enter,
  input  wire logic                 i_wake,
  input  wire logic                 i_dbg_mode,
  input  wire logic                 i_dbg_halt,
  output logic [NFLAG-1:0]          o_flags,
  output logic                      o_pwr_clr_rst,
  output logic                      o_sleep,
  output dth_pkg::dth_wr_s          o_wr
);

  // ==========================================================================
  // elaboration checks
  // ==========================================================================
  if (NFLAG < 1 || NFLAG > 32)
  begin : g_bad_nflag
    $error("NFLAG must be 1 to 32");
  end
  if (CLR_LEN < 2 || CLR_LEN > 255 || WIN_CYC > 255)
  begin : g_bad_cnt
    $error("CLR_LEN must be 2 to 255 and the window under 256 cycles");
  end

  localparam logic [CNT_W-1:0] WIN_LOAD = CNT_W'(WIN_CYC - 1);
  localparam logic [CNT_W-1:0] CLR_LOAD = CNT_W'(CLR_LEN - 1);

  dth_pstate_e       ps_ff;
  dth_pstate_e       nxt_ps;
  logic [CNT_W-1:0]  win_cnt_ff;
  logic [CNT_W-1:0]  nxt_win_cnt;
  logic [CNT_W-1:0]  clr_cnt_ff;
  logic [CNT_W-1:0]  nxt_clr_cnt;
  logic              soft_clr;
  logic              trig_hit;
  logic              rmw_busy_ff;
  logic              hazard_ff;
  logic              in_access;
  logic              lose;
  logic [NFLAG-1:0]  clr_eff;
  logic              dbg_s1_ff;
  logic              dbg_s2_ff;
  logic              dbg_s3_ff;
  logic              dbg_halt_ff;
  logic              dma_start;
  dth_wr_s           dma_wr;

  assign soft_clr = (ps_ff == PS_CLEAR);
  assign trig_hit = i_dma_en && i_dma_trig;

  // ==========================================================================
  // dma channel
  // ==========================================================================
  dth_dma_xfer u_xfer (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_ce    (i_ce),
    .i_clr   (soft_clr),
    .i_en    (i_dma_en),
    .i_trig  (i_dma_trig),
    .i_data  (i_src_data),
    .o_start (dma_start),
    .o_wr    (dma_wr)
  );

  // ==========================================================================
  // interrupt flags and the read-modify-write overlap
  // ==========================================================================
  assign in_access = i_rmw_rd || rmw_busy_ff;
  assign lose      = in_access && (hazard_ff || dma_start);
  assign clr_eff   = i_rmw_wr ? i_rmw_clr : '0;

  // access open from the read strobe until the write strobe
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      rmw_busy_ff <= 1'b0;
    else if (i_ce)
      rmw_busy_ff <= !soft_clr && in_access && !i_rmw_wr;
  end

  // remembers that a dma started inside the open access
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      hazard_ff <= 1'b0;
    else if (i_ce)
      hazard_ff <= !soft_clr && lose && !i_rmw_wr;
  end

  // old flags survive, events win over clears except while lost
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      o_flags <= '0;
    else if (i_ce)
    begin
      if (soft_clr)
        o_flags <= '0;
      else
        o_flags <= (o_flags & ~clr_eff) | (i_irq_evt & ~{NFLAG{lose}});
    end
  end

  // ==========================================================================
  // power sequencer with the sleep entry window
  // ==========================================================================
  always_comb
  begin
    nxt_ps      = ps_ff;
    nxt_win_cnt = win_cnt_ff;
    nxt_clr_cnt = clr_cnt_ff;
    case (ps_ff)
      PS_RUN:
      begin
        if (i_lpm_enter && dth_is_deep(i_lpm_mode))
        begin
          nxt_ps      = PS_ENTRY;
          nxt_win_cnt = WIN_LOAD;
        end
        else if (i_lpm_enter && i_lpm_mode == low_power_mode_zero)
          nxt_ps = PS_SLEEP;
      end
      PS_ENTRY:
      begin
        if (trig_hit)
        begin
          nxt_ps      = PS_CLEAR;
          nxt_clr_cnt = CLR_LOAD;
        end
        else if (win_cnt_ff == CNT_RST)
          nxt_ps = PS_SLEEP;
        else
          nxt_win_cnt = win_cnt_ff - 8'h01;
      end
      PS_SLEEP:
      begin
        if (i_wake)
          nxt_ps = PS_RUN;
      end
      PS_CLEAR:
      begin
        if (clr_cnt_ff == CNT_RST)
          nxt_ps = PS_RUN;
        else
          nxt_clr_cnt = clr_cnt_ff - 8'h01;
      end
      default:
        nxt_ps = PS_RUN;
    endcase
  end

  // sequencer state and counters
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      ps_ff      <= PS_RUN;
      win_cnt_ff <= CNT_RST;
      clr_cnt_ff <= CNT_RST;
    end
    else if (i_ce)
    begin
      ps_ff      <= nxt_ps;
      win_cnt_ff <= nxt_win_cnt;
      clr_cnt_ff <= nxt_clr_cnt;
    end
  end

  // registered reset and sleep indications
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_pwr_clr_rst <= 1'b0;
      o_sleep       <= 1'b0;
    end
    else if (i_ce)
    begin
      o_pwr_clr_rst <= (nxt_ps == PS_CLEAR);
      o_sleep       <= (nxt_ps == PS_SLEEP);
    end
  end

  // ==========================================================================
  // debug halt pin and write corruption
  // ==========================================================================
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      dbg_s1_ff   <= 1'b0;
      dbg_s2_ff   <= 1'b0;
      dbg_s3_ff   <= 1'b0;
      dbg_halt_ff <= 1'b0;
    end
    else if (i_ce)
    begin
      dbg_s1_ff <= i_dbg_halt;
      dbg_s2_ff <= dbg_s1_ff;
      dbg_s3_ff <= dbg_s2_ff;
      if (dbg_s2_ff == dbg_s3_ff)
        dbg_halt_ff <= dbg_s2_ff; // accepted once two stages agree
    end
  end

  // memory write port, spoiled while halted under debug control
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      o_wr <= '0;
    else if (i_ce)
    begin
      o_wr.valid   <= dma_wr.valid && !soft_clr;
      o_wr.corrupt <= dma_wr.valid && i_dbg_mode && dbg_halt_ff;
      o_wr.addr    <= dma_wr.addr;
      if (i_dbg_mode && dbg_halt_ff)
        o_wr.data <= dma_wr.data ^ CORRUPT_MASK;
      else
        o_wr.data <= dma_wr.data;
    end
  end

  // ==========================================================================
  // assertions
  // ==========================================================================
  localparam int A_WIN = WIN_CYC;
  localparam int A_CLR = CLR_LEN - 1;
  logic [CNT_W-1:0] run_cnt_ff;
  logic             in_win;

  assign in_win = (ps_ff == PS_ENTRY);

  // length of the current entry window, for the checks only
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      run_cnt_ff <= CNT_RST;
    else if (i_ce)
      run_cnt_ff <= in_win ? run_cnt_ff + 8'h01 : CNT_RST;
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst || !i_ce);

  sequence s_rmw_open;
    i_rmw_rd && !i_rmw_wr && !soft_clr;
  endsequence
  sequence s_dma_mid;
    dma_start && !i_rmw_wr && !soft_clr;
  endsequence

  a_hazard_mark: assert property (s_rmw_open ##1 s_dma_mid |=> hazard_ff)
    else $error("dma start inside access not remembered");
  a_lost_event: assert property ((lose && !i_rmw_wr && !soft_clr) |=> o_flags == $past(o_flags))
    else $error("flags changed while events are being lost");
  a_set_kept: assert property ((!lose && !soft_clr) |=> (o_flags & $past(i_irq_evt)) == $past(i_irq_evt))
    else $error("event outside the hazard was not recorded");
  a_prior_held: assert property (!soft_clr |=> ($past(o_flags) & ~$past(clr_eff) & ~o_flags) == '0)
    else $error("a flag set earlier was lost");
  a_clr_on_hit: assert property ((in_win && trig_hit) |=> o_pwr_clr_rst ##1 (o_flags == '0))
    else $error("trigger in entry window gave no reset");
  a_clr_length: assert property ($rose(o_pwr_clr_rst) |-> ##A_CLR o_pwr_clr_rst ##1 !o_pwr_clr_rst)
    else $error("power-up-clear reset has wrong length");
  a_window_max: assert property (run_cnt_ff <= CNT_W'(A_WIN))
    else $error("entry window too long");
  a_window_full: assert property (($fell(in_win) && !o_pwr_clr_rst) |-> run_cnt_ff == CNT_W'(A_WIN))
    else $error("entry window ended early");
  a_dbg_corrupt: assert property ((dma_wr.valid && i_dbg_mode && dbg_halt_ff && !soft_clr)
    |=> o_wr.corrupt && o_wr.data == ($past(dma_wr.data) ^ CORRUPT_MASK))
    else $error("halted debug write not corrupted");
  a_clean_write: assert property ((dma_wr.valid && !(i_dbg_mode && dbg_halt_ff) && !soft_clr)
    |=> o_wr.valid && !o_wr.corrupt && o_wr.data == $past(dma_wr.data))
    else $error("normal dma write altered");

endmodule

// file: testbench/dth_host_model.sv
// processor side model: issues dma triggers with a source word
// assumes the bench calls pulse() about 1 ns after a rising edge
`timescale 1ns/1ps
module dth_host_model
  import dth_pkg::*;
(
  input  wire logic              i_clk,
  output logic                   o_trig,
  output logic [DATA_W-1:0]      o_data
);
  // ==========================================================================
  // trigger driver
  // ==========================================================================
  initial
  begin
    o_trig = 1'b0;
    o_data = 16'hffff;
  end

  // trigger only on explicit command, never on its own during sleep entry
  // the bench brackets flag updates itself, so no hidden rmw here
  task automatic pulse(input logic [DATA_W-1:0] d, input int n);
    o_trig = 1'b1;
    o_data = d;
    repeat (n) @(posedge i_clk);
    #1;
    o_trig = 1'b0;
    o_data = ~d; // released data does not keep the last value
  endtask
endmodule

// file: testbench/testbench.sv
// self-checking bench for the dma trigger hazard model
// assumes a 100 MHz clock and the design's default parameters
`timescale 1ns/1ps
module testbench;
  import dth_pkg::*;

  // ==========================================================================
  // signals
  // ==========================================================================
  logic              i_clk = 1'b0;
  logic              i_rst = 1'b1;
  logic              dma_en = 1'b0;
  logic              ce = 1'b1;
  logic              trig;
  logic [15:0]       src;
  logic [7:0]        evt = 8'h00;
  logic              rmw_rd = 1'b0;
  logic              rmw_wr = 1'b0;
  logic [7:0]        rmw_clr = 8'h00;
  dth_pmode_e        mode = active_mode;
  logic              enter = 1'b0;
  logic              wake = 1'b0;
  logic              dbg_mode = 1'b0;
  logic              dbg_halt = 1'b0;
  logic [7:0]        flags;
  logic              rst_out;
  logic              sleep;
  dth_wr_s           wr;
  int                errors = 0;
  int                checked = 0;

  // clock of 10 ns
  always #5 i_clk = ~i_clk;

  dth_host_model i_host (.i_clk(i_clk), .o_trig(trig), .o_data(src));

  dth_dma_trigger_hazard_model i_dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_ce(ce), .i_dma_en(dma_en),
    .i_dma_trig(trig), .i_src_data(src), .i_irq_evt(evt), .i_rmw_rd(rmw_rd),
    .i_rmw_wr(rmw_wr), .i_rmw_clr(rmw_clr), .i_lpm_mode(mode),
    .i_lpm_enter(enter), .i_wake(wake), .i_dbg_mode(dbg_mode),
    .i_dbg_halt(dbg_halt), .o_flags(flags), .o_pwr_clr_rst(rst_out), .o_sleep(sleep),
    .o_wr(wr));

  // ==========================================================================
  // helpers
  // ==========================================================================
  task automatic step(input int n = 1);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    if (errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ==========================================================================
  // scenarios
  // ==========================================================================
  // held trigger: first taken, next cycle refused, third taken
  task automatic t_dma_write();
    dma_en = 1'b1;
    i_host.pulse(16'h3c5a, 3);
    check("wr0", wr, {1'b1, 1'b0, 16'h0000, 16'h3c5a});
    step();
    check("wr_gap", wr.valid, 1'b0);
    step();
    check("wr1", wr, {1'b1, 1'b0, 16'h0001, 16'h3c5a});
    step(2);
  endtask

  // dma start inside rmw drops the new event, keeps the old flag
  task automatic t_rmw_loss();
    evt = 8'h01;
    step();
    evt = 8'h00;
    rmw_rd = 1'b1;
    i_host.pulse(16'h0001, 1);
    rmw_rd = 1'b0;
    evt = 8'h02;
    step(2);
    evt = 8'h00;
    rmw_wr = 1'b1;
    step();
    rmw_wr = 1'b0;
    check("flags_rmw", flags, 8'h01);
    evt = 8'h04;
    step();
    evt = 8'h00;
    check("flags_after", flags, 8'h05);
  endtask

  // dma kept off around the access: new event kept, set wins over a same-cycle clear
  task automatic t_rmw_safe();
    dma_en = 1'b0;
    rmw_rd = 1'b1;
    i_host.pulse(16'h0055, 1);
    rmw_rd = 1'b0;
    evt = 8'h02;
    step();
    evt = 8'h01;
    rmw_wr = 1'b1;
    rmw_clr = 8'h05;
    step();
    evt = 8'h00;
    rmw_wr = 1'b0;
    rmw_clr = 8'h00;
    dma_en = 1'b1;
    check("flags_safe", flags, 8'h03);
    check("wr_refused", wr.valid, 1'b0);
  endtask

  // clock enable low: flags and sequencer hold their state
  task automatic t_freeze();
    ce = 1'b0;
    evt = 8'h10;
    enter = 1'b1;
    mode = low_power_mode_zero;
    step(2);
    check("flags_frozen", {flags, sleep}, {8'h03, 1'b0});
    enter = 1'b0;
    ce = 1'b1;
    step();
    evt = 8'h00;
    check("flags_thawed", {flags, sleep}, {8'h13, 1'b0});
  endtask

  // halted under debug control: written word is flagged and mangled
  task automatic t_debug();
    dbg_mode = 1'b1;
    dbg_halt = 1'b1;
    step(6);
    i_host.pulse(16'h1234, 1);
    step(2);
    check("wr_dbg", wr, {1'b1, 1'b1, 16'h0003, 16'h1234 ^ CORRUPT_MASK});
    dbg_halt = 1'b0;
    step(6);
    i_host.pulse(16'h1234, 1);
    step(2);
    check("wr_clean", wr, {1'b1, 1'b0, 16'h0004, 16'h1234});
    dbg_mode = 1'b0;
  endtask

  // trigger inside the entry window gives a reset of CLR_RST_CYC cycles
  task automatic t_reset_hit();
    enter = 1'b1;
    mode = low_power_mode_one;
    step();
    enter = 1'b0;
    step(9);
    i_host.pulse(16'h0f0f, 1);
    check("rst_on", rst_out, 1'b1);
    step(CLR_RST_CYC - 1);
    check("rst_held", {rst_out, flags}, {1'b1, 8'h00});
    step();
    check("rst_off", {rst_out, sleep}, 2'b00);
  endtask

  // each sleep mode, triggered only once asleep; deep ones wait out the window
  task automatic t_sleep();
    dth_pmode_e m;
    for (int k = 1; k <= 5; k++)
    begin
      m = dth_pmode_e'(k);
      mode = m;
      enter = 1'b1;
      step();
      enter = 1'b0;
      if (k > 1)
      begin
        step(WIN_CYC - 1);
        check("sleep_early", sleep, 1'b0);
        step();
      end
      check("sleep_on", sleep, 1'b1);
      i_host.pulse(16'h00aa, 1);
      check("rst_asleep", rst_out, 1'b0);
      wake = 1'b1;
      step();
      wake = 1'b0;
      check("sleep_off", sleep, 1'b0);
      step(2);
    end
    mode = active_mode;
    enter = 1'b1;
    step();
    enter = 1'b0;
    step(2);
    check("active_stay", {sleep, rst_out}, 2'b00);
  endtask

  // ==========================================================================
  // main sequence and watchdog
  // ==========================================================================
  initial
  begin
    step(8);
    i_rst = 1'b0;
    step();
    t_dma_write();
    t_rmw_loss();
    t_rmw_safe();
    t_freeze();
    t_debug();
    t_reset_hit();
    t_sleep();
    finish_test();
  end

  initial
  begin
    #50us;
    errors++;
    finish_test();
  end
endmodule
